// *** rtl/sdac_pkg.sv ***
// Shared constants for the serial DAC input interface and its host
package sdac_pkg;
    localparam int SDAC_WORD_BITS = 16;
    localparam int SDAC_SEG_BITS = 4;
    localparam int SDAC_SEG_COUNT = 15;
    localparam int SDAC_LADDER_BITS = 12;
    localparam int SDAC_CNT_BITS = 5;
    localparam logic [15:0] SDAC_RESET_CODE = 16'h0000;
    localparam logic [15:0] SDAC_MIDSCALE_CODE = 16'h8000;
    // Host side serial clock divider: link clock max 25 MHz
    localparam int SDAC_MCLK_MHZ = 40;
    localparam int SDAC_SCLK_MAX_MHZ = 25;
    localparam int SDAC_HALF_DIV = (SDAC_MCLK_MHZ + 2 * SDAC_SCLK_MAX_MHZ - 1)
        / (2 * SDAC_SCLK_MAX_MHZ);
    localparam int SDAC_GAP_CYCLES = 2;
    typedef enum logic [2:0] {
        SDAC_IDLE = 3'b000,
        SDAC_SETUP = 3'b001,
        SDAC_LOW = 3'b010,
        SDAC_HIGH = 3'b011,
        SDAC_END = 3'b100,
        SDAC_STROBE = 3'b101,
        SDAC_GAP = 3'b110
    } sdac_host_state_type;
endpackage : sdac_pkg

// *** rtl/sdac_link_if.sv ***
// Serial link between the host and the DAC input interface
`timescale 1ns/10ps
interface sdac_link_if;
    logic sclk;
    logic sdin;
    logic select_n;
    logic latch_update_n;
    modport host (output sclk, output sdin, output select_n, output latch_update_n);
    modport device (input sclk, input sdin, input select_n, input latch_update_n);
endinterface : sdac_link_if

// *** rtl/sdac_device.sv ***
// Documented device end: shift register, DAC register and switch decode
// ==========================================================================
`timescale 1ns/10ps
module sdac_device
    import sdac_pkg::*;
#(
    parameter int WORD_BITS = SDAC_WORD_BITS
) (
    // Reset
    input wire logic reset_n,
    // Link
    sdac_link_if.device link,
    // Converter drive
    output logic [SDAC_SEG_COUNT-1:0] segment_switches,
    output logic [SDAC_LADDER_BITS-1:0] ladder_switches,
    output logic [WORD_BITS-1:0] dac_code
);
    // ======================================================================
    // Shift register on the link clock
    logic [WORD_BITS-1:0] shift_word;
    logic [WORD_BITS-1:0] dac_reg;

    always_ff @(posedge link.sclk) begin
        if (!link.select_n) begin
            shift_word <= {shift_word[WORD_BITS-2:0], link.sdin};
        end
    end

    // ======================================================================
    // DAC register load
    // The serial clock may stop after the frame, so the load is taken on
    // the select and update edges themselves rather than on sclk.
    logic upd_fire;
    // update strobe when select is high
    assign upd_fire = ~link.latch_update_n & link.select_n;

    // frame end and update strobe load, zero at reset
    always_ff @(posedge link.select_n or posedge upd_fire or negedge reset_n) begin
        if (!reset_n) begin
            dac_reg <= SDAC_RESET_CODE;
        end else begin
            dac_reg <= shift_word;
        end
    end

    // ======================================================================
    // Switch decode
    logic [SDAC_SEG_BITS-1:0] upper;
    assign upper = dac_reg[WORD_BITS-1 -: SDAC_SEG_BITS];
    always_comb begin
        for (int k = 0; k < SDAC_SEG_COUNT; k++) begin
            segment_switches[k] = ({1'b0, upper} >= 5'(k + 1));
        end
    end
    assign ladder_switches = dac_reg[SDAC_LADDER_BITS-1:0];
    assign dac_code = dac_reg;
endmodule : sdac_device

// *** rtl/sdac_host.sv ***
// Host end: sends one 16-bit word per request, optional update strobe
`timescale 1ns/10ps
module sdac_host
    import sdac_pkg::*;
#(
    parameter int WORD_BITS = SDAC_WORD_BITS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [WORD_BITS-1:0] req_word,
    input wire logic use_update,
    // Link
    sdac_link_if.host link
);
    sdac_host_state_type state;
    logic [WORD_BITS-1:0] shreg;
    logic [SDAC_CNT_BITS-1:0] bits_left;
    logic [3:0] div;
    logic strobe_mode;

    assign req_ready = (state == SDAC_IDLE);

    // ======================================================================
    // Frame sequencer; sclk is derived from mclk, at most 25 MHz
    // framed MSB-first, update held high except for a one-cycle low strobe after the frame when use_update is set
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SDAC_IDLE;
            shreg <= '0;
            bits_left <= '0;
            div <= '0;
            strobe_mode <= 1'b0;
            link.sclk <= 1'b0;
            link.sdin <= 1'b0;
            link.select_n <= 1'b1;
            link.latch_update_n <= 1'b1;
        end else begin
            case (state)
                SDAC_IDLE: begin
                    if (req_valid) begin
                        shreg <= req_word;
                        strobe_mode <= use_update;
                        bits_left <= SDAC_CNT_BITS'(WORD_BITS);
                        link.select_n <= 1'b0;
                        div <= '0;
                        state <= SDAC_SETUP;
                    end
                end
                SDAC_SETUP: begin
                    link.sdin <= shreg[WORD_BITS-1];
                    shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                    state <= SDAC_LOW;
                end
                SDAC_LOW: begin
                    if (div == 4'(SDAC_HALF_DIV - 1)) begin
                        div <= '0;
                        link.sclk <= 1'b1;
                        bits_left <= bits_left - 1'b1;
                        state <= SDAC_HIGH;
                    end else begin
                        div <= div + 1'b1;
                    end
                end
                SDAC_HIGH: begin
                    if (div == 4'(SDAC_HALF_DIV - 1)) begin
                        div <= '0;
                        link.sclk <= 1'b0;
                        if (bits_left == '0) begin
                            state <= SDAC_END;
                        end else begin
                            link.sdin <= shreg[WORD_BITS-1];
                            shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                            state <= SDAC_LOW;
                        end
                    end else begin
                        div <= div + 1'b1;
                    end
                end
                SDAC_END: begin
                    link.select_n <= 1'b1;
                    state <= strobe_mode ? SDAC_STROBE : SDAC_GAP;
                end
                SDAC_STROBE: begin
                    if (link.latch_update_n) begin
                        link.latch_update_n <= 1'b0;
                    end else begin
                        link.latch_update_n <= 1'b1;
                        state <= SDAC_GAP;
                    end
                end
                SDAC_GAP: begin
                    if (div == 4'(SDAC_GAP_CYCLES - 1)) begin
                        div <= '0;
                        state <= SDAC_IDLE;
                    end else begin
                        div <= div + 1'b1;
                    end
                end
                default: begin
                    state <= SDAC_IDLE;
                end
            endcase
        end
    end
endmodule : sdac_host

// *** sim/sdac_sva.sv ***
// Assertions on the serial link and the converter drive
`timescale 1ns/10ps
module sdac_sva
    import sdac_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Link
    input wire logic sclk,
    input wire logic sdin,
    input wire logic select_n,
    input wire logic latch_update_n,
    // Converter drive
    input wire logic [SDAC_SEG_COUNT-1:0] segment_switches,
    input wire logic [SDAC_LADDER_BITS-1:0] ladder_switches,
    input wire logic [SDAC_WORD_BITS-1:0] dac_code
);
    logic sclk_q;
    logic [15:0] shadow;
    logic [4:0] rises;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ==================================================================
    // Shadow shift register, no reset like the real one
    always_ff @(posedge mclk) begin
        sclk_q <= sclk;
    end
    always_ff @(posedge mclk) begin
        if (!select_n && sclk && !sclk_q) begin
            shadow <= {shadow[14:0], sdin};
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rises <= 5'h00;
        end else if (select_n) begin
            rises <= 5'h00;
        end else if (sclk && !sclk_q) begin
            rises <= rises + 5'h01;
        end
    end
    // ==================================================================
    sequence s_frame_end; $rose(select_n); endsequence
    property p_therm; segment_switches == (15'h7FFF >> (4'hF - dac_code[15:12])); endproperty
    a_therm: assert property (p_therm) else $error("segment decode wrong");
    property p_ladder; ladder_switches == dac_code[11:0]; endproperty
    a_ladder: assert property (p_ladder) else $error("ladder drive wrong");
    property p_hold; (!select_n ##1 !select_n) |-> $stable(dac_code); endproperty
    a_hold: assert property (p_hold) else $error("code moved inside frame");
    property p_count; s_frame_end |-> rises == 5'h10; endproperty
    a_count: assert property (p_count) else $error("frame bit count wrong");
    property p_load; s_frame_end |=> dac_code == shadow; endproperty
    a_load: assert property (p_load) else $error("code not loaded at frame end");
    property p_pulse; $fell(latch_update_n) |=> latch_update_n; endproperty
    a_pulse: assert property (p_pulse) else $error("update strobe too long");
    property p_upd_out; !latch_update_n |-> select_n; endproperty
    a_upd_out: assert property (p_upd_out) else $error("update strobe inside frame");
    property p_gap; s_frame_end |=> select_n [*2]; endproperty
    a_gap: assert property (p_gap) else $error("frames too close");
endmodule : sdac_sva

// *** sim/serial_dac_input_interface_tb.sv ***
// Self-checking bench: host and device joined by the serial link
`timescale 1ns/10ps
module serial_dac_input_interface_tb
    import sdac_pkg::*;
;
    logic mclk;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready;
    logic [15:0] req_word = 16'h0000;
    logic use_update = 1'b0;
    logic [14:0] segment_switches;
    logic [11:0] ladder_switches;
    logic [15:0] dac_code;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    sdac_link_if link ();
    sdac_host i_sdac_host (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_word(req_word), .use_update(use_update), .link(link));
    sdac_device i_sdac_device (.reset_n(reset_n), .link(link),
        .segment_switches(segment_switches), .ladder_switches(ladder_switches),
        .dac_code(dac_code));
    sdac_sva i_sdac_sva (.mclk(mclk), .reset_n(reset_n), .sclk(link.sclk), .sdin(link.sdin),
        .select_n(link.select_n), .latch_update_n(link.latch_update_n),
        .segment_switches(segment_switches), .ladder_switches(ladder_switches),
        .dac_code(dac_code));
    // ==================================================================
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic print_verdict;
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One word through the host, then the converter drive is compared
    task automatic write_check(input logic [15:0] word, input logic upd);
        @(negedge mclk);
        req_word = word;
        use_update = upd;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        for (int n = 0; n < 60 && req_ready !== 1'b1; n++) @(negedge mclk);
        check(dac_code, word, "dac_code");
        check({1'b0, segment_switches}, {1'b0, 15'h7FFF >> (4'hF - word[15:12])}, "seg");
        check({4'h0, ladder_switches}, {4'h0, word[11:0]}, "ladder");
    endtask : write_check
    // Cuts a hung handshake short; a full run needs under 800 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        check(dac_code, 16'h0000, "reset code");
        write_check(16'h8000, 1'b0);
        for (int k = 0; k < 16; k++) begin
            write_check({k[3:0], 12'hA5C ^ {3{k[3:0]}}}, k[0]);
        end
        // Reset again in mid-run: the code must drop back to zero
        @(negedge mclk);
        reset_n = 1'b0;
        @(negedge mclk);
        check(dac_code, SDAC_RESET_CODE, "mid reset code");
        reset_n = 1'b1;
        write_check(16'hFFFF, 1'b1);
        print_verdict();
    end
endmodule : serial_dac_input_interface_tb
